// >>> src/uart_regs.svh
// Purpose: register map, field positions and reset values of the serial channel
// Assumes: 32-bit APB, one aligned word per register
// Notes: definitions only
`ifndef UART_REGS_SVH
`define UART_REGS_SVH
// How it works
// (RULE1) Running clock keeps transfers going normally
// (RULE2) Stopped clock freezes every register value
// (RULE3) Stopped clock holds the serial output level
// (RULE4) Software clears power and enables after resume
// (RULE5) Software sets power before either enable
// (RULE6) Enables resynchronised to the base clock
// (RULE7) Software waits two base clocks before re-enabling
// (RULE8) Software loads next character after done interrupt
// (RULE9) Software clears transmit enable before power
// (RULE10) Low line at enable starts reception at once
// (RULE11) Software clears enables before format changes
// (RULE12) Receiver always uses one stop bit
// (RULE13) Overrun discards the newly received character
// (RULE14) Done interrupt after last stop bit
// (RULE15) Power off returns everything to idle
`define OFF_MODE 8'h00
`define OFF_BAUD 8'h04
`define OFF_TXDATA 8'h08
`define OFF_RXDATA 8'h0C
`define OFF_STATUS 8'h10
`define OFF_IRQ_STAT 8'h14
`define OFF_IRQ_CLR 8'h18
`define OFF_IRQ_EN 8'h1C
`define MODE_W 7
`define BAUD_W 11
`define MODE_RESET 7'h00
`define BAUD_RESET 11'h010
`define IRQ_W 3
`define IRQ_TXDONE 0
`define IRQ_RXDONE 1
`define IRQ_RXERR 2
`define ERR_PARITY 0
`define ERR_FRAME 1
`define ERR_OVERRUN 2
`define FRAME_W 12
`endif

// >>> src/uart_pkg.sv
// Purpose: shared types of the serial channel
// Assumes: field layouts match the register header
// Notes: nothing here is imported
package uart_pkg;
	typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} parity_t;
	// Mode register layout, power in bit 0
	typedef struct packed {
		logic stop_length_select;
		logic char_length_select;
		parity_t parity_select;
		logic receive_enable_bit;
		logic transmit_enable_bit;
		logic unit_power_on;
	} mode_t;
	// Baud generator control: base clock = core / 2**base_sel, bit = bit_div+1 base clocks
	typedef struct packed {
		logic [2:0] base_sel;
		logic [7:0] bit_div;
	} baud_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : uart_pkg

// >>> src/uart_tx.sv
// Purpose: transmit shift register and frame sequencing
// Assumes: run gates every update, clear returns to idle
// Notes: line idles high
`timescale 1ns/10ps
`include "uart_regs.svh"
module uart_tx (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic clear,
	input wire logic base_tick,
	input wire logic [7:0] bit_div,
	input wire uart_pkg::mode_t mode,
	input wire logic load,
	input wire logic [7:0] data,
	output logic txd,
	output logic busy,
	output logic done
);
	logic [`FRAME_W-1:0] shift_q;
	logic [`FRAME_W-1:0] frame_d;
	logic [3:0] left_q;
	logic [3:0] len_d;
	logic [3:0] nd;
	logic [7:0] tick_q;
	logic txd_q;
	logic done_q;
	logic par;
	logic bit_end;

	assign busy = left_q != 4'h0;
	assign bit_end = base_tick && busy && (tick_q == bit_div);
	assign txd = txd_q;
	assign done = done_q;

	always_comb begin
		nd = mode.char_length_select ? 4'h8 : 4'h7;
		par = ^(mode.char_length_select ? data : {1'b0, data[6:0]});
		frame_d = '1;
		frame_d[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(nd))
				frame_d[i+1] = data[i];
		end
		case (mode.parity_select)
			uart_pkg::PAR_ZERO: frame_d[nd+4'h1] = 1'b0;
			uart_pkg::PAR_ODD: frame_d[nd+4'h1] = ~par;
			uart_pkg::PAR_EVEN: frame_d[nd+4'h1] = par;
			default: ;
		endcase
		len_d = nd + 4'h2 + {3'h0, mode.parity_select != uart_pkg::PAR_NONE} + {3'h0, mode.stop_length_select};
	end

	// (RULE2) frozen without clock
	always_ff @(posedge clk) begin
		if (rst) begin
			shift_q <= '1;
			left_q <= 4'h0;
			tick_q <= 8'h00;
			txd_q <= 1'b1;
			done_q <= 1'b0;
		end else if (run) begin
			done_q <= 1'b0;
			tick_q <= (bit_end || !busy) ? 8'h00 : (base_tick ? tick_q + 8'h01 : tick_q);
			// (RULE15) idle and high on clear
			if (clear) begin
				left_q <= 4'h0;
				txd_q <= 1'b1;
			end else if (load && !busy) begin
				shift_q <= frame_d >> 1;
				left_q <= len_d;
				txd_q <= 1'b0;
			end else if (bit_end) begin
				left_q <= left_q - 4'h1;
				shift_q <= {1'b1, shift_q[`FRAME_W-1:1]};
				txd_q <= (left_q == 4'h1) ? 1'b1 : shift_q[0];
				// (RULE14) done after last stop
				done_q <= left_q == 4'h1;
			end
		end
	end

	a_load_start: assert property (@(posedge clk) disable iff (rst) // load begins frame with start bit
		(run && !clear && load && !busy) |=> (!txd && busy))
		else $error("transmit frame did not begin with start bit");
endmodule : uart_tx

// >>> src/uart_enable_sequencing.sv
// Purpose: APB-controlled serial channel with enable sequencing and clock-stop freeze
// Assumes: CLK_SUPPLY low means the unit clock is stopped
// Notes: APB answers in the access cycle, no wait states
`timescale 1ns/10ps
`include "uart_regs.svh"
module uart_enable_sequencing (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CLK_SUPPLY,
	input wire logic SERIAL_IN_LINE,
	output logic SERIAL_OUT_LINE,
	output logic IRQ
);
	uart_pkg::mode_t mode_q;
	uart_pkg::baud_t baud_q;
	uart_pkg::rx_state_t rx_q, rx_d;
	logic [7:0] presc_q, mask;
	logic txe_s1_q, txe_s2_q, rxe_s1_q, rxe_s2_q;
	logic run, base_tick, tx_en, rx_en;
	logic setup, access, we, rd;
	logic sel_mode, sel_baud, sel_tx, sel_rx, sel_st, sel_is, sel_ic, sel_ie, mapped;
	logic [31:0] rdata;
	logic [7:0] cnt_q, target, sh_q, sh_d, rxbuf_q, rx_word;
	logic [3:0] bits_q, bits_d, nd;
	logic par_q, par_d, par_en, rx_sample, finish, pe_now, rx_full_q;
	logic [`IRQ_W-1:0] err_q, err_set, irq_q, irq_set, irq_en_q, irq_clr, err_clr;
	logic tx_busy, tx_done, tx_load;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = a == off;
	endfunction : hit

	// (RULE1) advances whenever supplied
	assign run = CLK_SUPPLY;
	assign mask = (8'h01 << baud_q.base_sel) - 8'h01;
	assign base_tick = run && ((presc_q & mask) == mask);
	assign tx_en = mode_q.unit_power_on && txe_s2_q;
	assign rx_en = mode_q.unit_power_on && rxe_s2_q;

	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE;
	// Writes while the unit clock is stopped are lost, matching a frozen unit
	assign we = access && PWRITE && run;
	assign rd = access && !PWRITE;
	assign sel_mode = hit(PADDR, `OFF_MODE);
	assign sel_baud = hit(PADDR, `OFF_BAUD);
	assign sel_tx = hit(PADDR, `OFF_TXDATA);
	assign sel_rx = hit(PADDR, `OFF_RXDATA);
	assign sel_st = hit(PADDR, `OFF_STATUS);
	assign sel_is = hit(PADDR, `OFF_IRQ_STAT);
	assign sel_ic = hit(PADDR, `OFF_IRQ_CLR);
	assign sel_ie = hit(PADDR, `OFF_IRQ_EN);
	assign mapped = sel_mode | sel_baud | sel_tx | sel_rx | sel_st | sel_is | sel_ic | sel_ie;
	assign PREADY = access;
	assign PSLVERR = access && !mapped;
	assign rdata = sel_mode ? 32'(mode_q) :
		sel_baud ? 32'(baud_q) :
		sel_rx ? {24'h00_0000, rxbuf_q} :
		sel_st ? 32'({tx_busy, rx_full_q, err_q}) :
		sel_is ? 32'(irq_q) :
		sel_ie ? 32'(irq_en_q) : 32'h0000_0000;

	// Only bits already shown to software are cleared, so a fresh event survives
	assign err_clr = (rd && sel_st && run) ? PRDATA[`IRQ_W-1:0] : '0;
	assign irq_clr = (we && sel_ic) ? PWDATA[`IRQ_W-1:0] : '0;
	// (RULE8) load refused while busy
	assign tx_load = we && sel_tx && tx_en && !tx_busy;
	assign IRQ = |(irq_q & irq_en_q);

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			PRDATA <= 32'h0000_0000;
		else if (setup && !PWRITE)
			PRDATA <= rdata;
	end

	// (RULE2) registers freeze with the clock
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			mode_q <= uart_pkg::mode_t'(`MODE_RESET);
			baud_q <= uart_pkg::baud_t'(`BAUD_RESET);
			irq_en_q <= '0;
			presc_q <= 8'h00;
		end else if (run) begin
			presc_q <= presc_q + 8'h01;
			if (we && sel_mode)
				mode_q <= uart_pkg::mode_t'(PWDATA[`MODE_W-1:0]);
			if (we && sel_baud)
				baud_q <= uart_pkg::baud_t'(PWDATA[`BAUD_W-1:0]);
			if (we && sel_ie)
				irq_en_q <= PWDATA[`IRQ_W-1:0];
		end
	end

	// (RULE6) enables cross on base clock
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			txe_s1_q <= 1'b0;
			txe_s2_q <= 1'b0;
			rxe_s1_q <= 1'b0;
			rxe_s2_q <= 1'b0;
		end else if (base_tick) begin
			txe_s1_q <= mode_q.transmit_enable_bit;
			txe_s2_q <= txe_s1_q;
			rxe_s1_q <= mode_q.receive_enable_bit;
			rxe_s2_q <= rxe_s1_q;
		end
	end

	// (RULE3) line held by frozen flop
	uart_tx u_tx (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.run(run),
		.clear(!tx_en),
		.base_tick(base_tick),
		.bit_div(baud_q.bit_div),
		.mode(mode_q),
		.load(tx_load),
		.data(PWDATA[7:0]),
		.txd(SERIAL_OUT_LINE),
		.busy(tx_busy),
		.done(tx_done)
	);

	assign nd = mode_q.char_length_select ? 4'h8 : 4'h7;
	assign par_en = mode_q.parity_select != uart_pkg::PAR_NONE;
	assign target = (rx_q == uart_pkg::RX_START) ? {1'b0, baud_q.bit_div[7:1]} : baud_q.bit_div;
	assign rx_sample = base_tick && (cnt_q == target) && (rx_q != uart_pkg::RX_IDLE);
	assign rx_word = mode_q.char_length_select ? sh_q : {1'b0, sh_q[7:1]};

	always_comb begin
		rx_d = rx_q;
		bits_d = bits_q;
		sh_d = sh_q;
		par_d = par_q;
		finish = 1'b0;
		case (rx_q)
			// (RULE10) low level starts reception
			uart_pkg::RX_IDLE: if (!SERIAL_IN_LINE) begin
				rx_d = uart_pkg::RX_START;
				bits_d = 4'h0;
			end
			uart_pkg::RX_START: if (rx_sample) rx_d = uart_pkg::RX_DATA;
			uart_pkg::RX_DATA: if (rx_sample) begin
				sh_d = {SERIAL_IN_LINE, sh_q[7:1]};
				bits_d = bits_q + 4'h1;
				if (bits_q == nd - 4'h1)
					rx_d = par_en ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
			end
			uart_pkg::RX_PAR: if (rx_sample) begin
				par_d = SERIAL_IN_LINE;
				rx_d = uart_pkg::RX_STOP;
			end
			// (RULE12) single stop bit sampled
			uart_pkg::RX_STOP: if (rx_sample) begin
				finish = 1'b1;
				rx_d = uart_pkg::RX_IDLE;
			end
			default: rx_d = uart_pkg::RX_IDLE;
		endcase
		// (RULE15) receiver idle when disabled
		if (!rx_en) begin
			rx_d = uart_pkg::RX_IDLE;
			finish = 1'b0;
		end
	end

	always_comb begin
		case (mode_q.parity_select)
			uart_pkg::PAR_ZERO: pe_now = par_q;
			uart_pkg::PAR_ODD: pe_now = ~(^rx_word ^ par_q);
			uart_pkg::PAR_EVEN: pe_now = ^rx_word ^ par_q;
			default: pe_now = 1'b0;
		endcase
	end

	assign err_set = finish ? {rx_full_q, !SERIAL_IN_LINE, pe_now} : '0;
	assign irq_set = {err_set != '0, finish && !rx_full_q, tx_done};

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rx_q <= uart_pkg::RX_IDLE;
			cnt_q <= 8'h00;
			bits_q <= 4'h0;
			sh_q <= 8'h00;
			par_q <= 1'b0;
		end else if (run) begin
			rx_q <= rx_d;
			cnt_q <= (rx_q == uart_pkg::RX_IDLE || rx_sample) ? 8'h00 : (base_tick ? cnt_q + 8'h01 : cnt_q);
			bits_q <= bits_d;
			sh_q <= sh_d;
			par_q <= par_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rxbuf_q <= 8'h00;
			rx_full_q <= 1'b0;
			err_q <= '0;
			irq_q <= '0;
		end else if (run) begin
			irq_q <= (irq_q & ~irq_clr) | irq_set;
			// (RULE15) power off clears errors
			if (!mode_q.unit_power_on) begin
				rx_full_q <= 1'b0;
				err_q <= '0;
			end else begin
				err_q <= (err_q & ~err_clr) | err_set;
				// (RULE13) overrun drops new data
				if (finish && !rx_full_q) begin
					rxbuf_q <= rx_word;
					rx_full_q <= 1'b1;
				end else if (rd && sel_rx) begin
					rx_full_q <= 1'b0;
				end
			end
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	a_freeze_state: assert property (!CLK_SUPPLY |=> $stable(rx_q) && $stable(irq_q) && $stable(mode_q)) // (RULE2)
		else $error("state changed while unit clock stopped");
	a_line_held: assert property (!CLK_SUPPLY |=> $stable(SERIAL_OUT_LINE)) // (RULE3)
		else $error("serial output moved while unit clock stopped");
	// Reset edge excluded: the prescaler is still held there
	a_run_counts: assert property ((CLK_SUPPLY && !SYS_RST) |=> presc_q == $past(presc_q) + 8'h01) // (RULE1)
		else $error("prescaler stalled with clock supplied");
	a_sync_delay: assert property ($rose(txe_s2_q) |-> $past(base_tick) && $past(txe_s1_q, 1)) // (RULE6)
		else $error("transmit enable took effect without resync");
	a_rx_start: assert property ((run && rx_en && rx_q == uart_pkg::RX_IDLE && !SERIAL_IN_LINE) // (RULE10)
		|=> rx_q == uart_pkg::RX_START)
		else $error("low line at enable did not start reception");
	a_one_stop: assert property ((run && rx_en && rx_q == uart_pkg::RX_STOP && rx_sample) // (RULE12)
		|=> rx_q == uart_pkg::RX_IDLE)
		else $error("receiver waited for a second stop bit");
	a_overrun_drop: assert property ((run && finish && rx_full_q) |=> $stable(rxbuf_q) && err_q[`ERR_OVERRUN]) // (RULE13)
		else $error("overrun character was not discarded");
	a_done_irq: assert property ((run && tx_done) |=> irq_q[`IRQ_TXDONE]) // (RULE14)
		else $error("transmit done did not set status");
	a_power_idle: assert property ((run && !mode_q.unit_power_on) [*2] |-> // (RULE15)
		rx_q == uart_pkg::RX_IDLE && SERIAL_OUT_LINE && !tx_busy && err_q == '0)
		else $error("power off did not return channel to idle");

	c_tx_done: cover property (tx_done);
	c_rx_done: cover property (finish && !rx_full_q);
	c_overrun: cover property (finish && rx_full_q);
	c_freeze: cover property (tx_busy && !CLK_SUPPLY);
endmodule : uart_enable_sequencing

// >>> verif/uart_far_end.sv
// Purpose: far-end serial device, 8 data bits, no parity
// Assumes: BIT core cycles per bit, line idles high
// Notes: our send line rests high, as with a pull-up
`timescale 1ns/10ps
module uart_far_end #(
	parameter int BIT = 4
) (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out,
	output logic [7:0] got_q
);
	initial begin
		line_out = 1'h1;
		got_q = 8'h00;
	end
	// One stop bit only, so frames can run back to back
	task automatic send(input logic [7:0] b);
		line_out <= 1'h0;
		repeat (BIT) @(posedge clk);
		for (int k = 0; k < 8; k++) begin
			line_out <= b[k];
			repeat (BIT) @(posedge clk);
		end
		line_out <= 1'h1;
		repeat (BIT) @(posedge clk);
	endtask : send
	// Mid-bit sampling, LSB first
	always begin
		@(posedge clk);
		if (line_in === 1'h0) begin
			repeat (BIT / 2) @(posedge clk);
			for (int k = 0; k < 8; k++) begin
				repeat (BIT) @(posedge clk);
				got_q[k] = line_in;
			end
			repeat (BIT) @(posedge clk);
		end
	end
endmodule : uart_far_end

// >>> verif/uart_enable_sequencing_tb_top.sv
// Purpose: self-checking bench of the serial channel
// Assumes: base_sel 0 and bit_div 3, so a bit is 4 cycles
// Notes: APB answers at once, but every wait is bounded
`timescale 1ns/10ps
`include "uart_regs.svh"
module uart_enable_sequencing_tb_top;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, clk_supply, sin, sout, irq, rerr;
	logic [7:0] paddr, got;
	logic [31:0] pwdata, prdata, rdata;
	int mismatches, cmp_count;
	uart_enable_sequencing u_dut (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CLK_SUPPLY(clk_supply), .SERIAL_IN_LINE(sin), .SERIAL_OUT_LINE(sout), .IRQ(irq));
	uart_far_end #(.BIT(4)) u_far (.clk(clk), .line_in(sout), .line_out(sin), .got_q(got));
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: expected %h, got %h", $time, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1) begin
			mismatches++;
			$display("Error at %0t: expected %h, got %h", $time, 1'h1, pready);
			end_sim();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'h0, a, 8'h00);
	endtask : rd
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'h1 && n < 600) begin
			@(posedge clk);
			n++;
		end
		if (irq !== 1'h1) begin
			mismatches++;
			$display("Error at %0t: expected %h, got %h", $time, 1'h1, irq);
			end_sim();
		end
	endtask : wait_irq
	task automatic t_reset;
		rd(`OFF_MODE);
		chk(8'h00, rdata[7:0]);
		rd(`OFF_BAUD);
		chk(8'h10, rdata[7:0]);
		rd(8'h20);
		chk(8'h00, rdata[7:0]);
		chk(8'h01, {7'h00, rerr});
		chk(8'h00, {7'h00, irq});
	endtask : t_reset
	task automatic tx1(input logic [7:0] b);
		wr(`OFF_TXDATA, b);
		wait_irq();
		chk(b, got);
	endtask : tx1
	task automatic t_tx;
		wr(`OFF_BAUD, 8'h03);
		wr(`OFF_MODE, 8'h21);
		wr(`OFF_MODE, 8'h23);
		repeat (4) @(posedge clk);
		wr(`OFF_IRQ_EN, 8'h01);
		tx1(8'h55);
		rd(`OFF_IRQ_STAT);
		chk(8'h01, rdata[7:0]);
		wr(`OFF_IRQ_EN, 8'h00);
		chk(8'h00, {7'h00, irq});
		wr(`OFF_IRQ_EN, 8'h01);
		chk(8'h01, {7'h00, irq});
		wr(`OFF_IRQ_CLR, 8'h01);
		chk(8'h00, {7'h00, irq});
		tx1(8'hA6);
		wr(`OFF_IRQ_CLR, 8'h01);
	endtask : t_tx
	task automatic t_rx;
		wr(`OFF_MODE, 8'h21);
		repeat (4) @(posedge clk);
		wr(`OFF_MODE, 8'h61);
		wr(`OFF_MODE, 8'h65);
		wr(`OFF_IRQ_EN, 8'h02);
		repeat (4) @(posedge clk);
		u_far.send(8'hA3);
		wait_irq();
		rd(`OFF_RXDATA);
		chk(8'hA3, rdata[7:0]);
		wr(`OFF_IRQ_CLR, 8'h07);
		u_far.send(8'h3C);
		u_far.send(8'h5A);
		repeat (8) @(posedge clk);
		// Back-to-back frames: no framing error with two-stop setting
		rd(`OFF_STATUS);
		chk(8'h0C, rdata[7:0]);
		rd(`OFF_RXDATA);
		chk(8'h3C, rdata[7:0]);
		wr(`OFF_IRQ_CLR, 8'h07);
	endtask : t_rx
	task automatic t_freeze;
		int hold;
		wr(`OFF_MODE, 8'h21);
		repeat (4) @(posedge clk);
		wr(`OFF_MODE, 8'h23);
		repeat (4) @(posedge clk);
		wr(`OFF_TXDATA, 8'hF0);
		// Freeze inside the start bit, so the held level is low
		clk_supply <= 1'h0;
		hold = 0;
		repeat (20) begin
			@(posedge clk);
			if (sout === 1'h0)
				hold++;
		end
		chk(8'h14, hold[7:0]);
		wr(`OFF_MODE, 8'h00);
		rd(`OFF_MODE);
		chk(8'h23, rdata[7:0]);
		chk(8'h00, {7'h00, sout});
		clk_supply <= 1'h1;
		@(posedge clk);
		wr(`OFF_MODE, 8'h21);
		wr(`OFF_MODE, 8'h00);
		chk(8'h01, {7'h00, sout});
		rd(`OFF_STATUS);
		chk(8'h00, rdata[7:0]);
	endtask : t_freeze
	task automatic t_fmt;
		int n;
		// 7-bit, even parity, two stops; format set while both enables are clear
		wr(`OFF_MODE, 8'h59);
		repeat (4) @(posedge clk);
		wr(`OFF_MODE, 8'h5B);
		repeat (4) @(posedge clk);
		wr(`OFF_IRQ_CLR, 8'h07);
		wr(`OFF_IRQ_EN, 8'h01);
		wr(`OFF_TXDATA, 8'h07);
		n = 0;
		while (irq !== 1'h1 && n < 600) begin
			@(posedge clk);
			n++;
		end
		// Eleven bits of four cycles, status one edge after the last
		chk(8'h2D, n[7:0]);
		if (irq !== 1'h1)
			end_sim();
		// Far end takes the parity bit as its eighth bit
		chk(8'h87, got);
		wr(`OFF_MODE, 8'h59);
		repeat (4) @(posedge clk);
		wr(`OFF_MODE, 8'h00);
		wr(`OFF_IRQ_CLR, 8'h01);
	endtask : t_fmt
	initial begin
		rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		clk_supply = 1'h1;
		mismatches = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_reset();
		t_tx();
		t_rx();
		t_freeze();
		t_fmt();
		end_sim();
	end
endmodule : uart_enable_sequencing_tb_top
